// [hdl/sst_pkg.sv]
// Package with constants shared by the serial slave front end
package sst_pkg;
    localparam int unsigned CLK_HZ            = 10_000_000;
    localparam int unsigned TIMEOUT_MIN_MS    = 25;
    localparam int unsigned TIMEOUT_MAX_MS    = 35;
    // Aim at the middle of the window; must lie between min and max
    localparam int unsigned TIMEOUT_MS        = 30;
    localparam int unsigned TIMEOUT_CYC       = CLK_HZ / 1000 * TIMEOUT_MS;
    localparam int unsigned GLITCH_NS         = 100;
    localparam int unsigned CLK_NS            = 1_000_000_000 / CLK_HZ;
    // Filter must outlast the longest spike, so it rounds up plus one
    localparam int unsigned GLITCH_CYC        = (GLITCH_NS + CLK_NS - 1) / CLK_NS + 1;
    localparam int unsigned POWERUP_MS        = 100;
    localparam int unsigned POWERUP_CYC       = CLK_HZ / 1000 * POWERUP_MS;
    localparam logic [3:0]  PREAMBLE_SENSOR   = 4'h3;
    localparam logic [3:0]  PREAMBLE_STORE    = 4'ha;
    localparam logic [3:0]  ACK_BIT           = 4'h8;
    localparam logic [3:0]  BYTE_LAST_BIT     = 4'h7;

    typedef enum logic [2:0]
    {
        SST_IDLE  = 3'b000,
        SST_ADDR  = 3'b001,
        SST_AACK  = 3'b010,
        SST_WDATA = 3'b011,
        SST_DACK  = 3'b100,
        SST_RDATA = 3'b101,
        SST_MACK  = 3'b110
    } sst_state_e;
endpackage : sst_pkg

// [hdl/sst_pin_filter.sv]
// Two-flop synchroniser followed by a spike-suppressing stability filter
`timescale 1ns/1ps
module sst_pin_filter
    import sst_pkg::*;
#(
    parameter int unsigned FILT_CYC = GLITCH_CYC
)
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic resetn,
    // Pin in, clean level out
    input  wire logic pinIn,
    output logic      levelOut
);
    typedef struct packed
    {
        logic       meta;
        logic       sync;
        logic       level;
        logic [7:0] cnt;
    } sst_filt_s;

    sst_filt_s filt_reg;
    sst_filt_s filt_next;

    always_comb
    begin
        filt_next      = filt_reg;
        filt_next.meta = pinIn;
        filt_next.sync = filt_reg.meta;
        // Level changes only after it holds steady past the spike width
        if (filt_reg.sync == filt_reg.level)
            filt_next.cnt = 8'h00;
        else if (filt_reg.cnt >= 8'(FILT_CYC - 1))
        begin
            filt_next.level = filt_reg.sync;
            filt_next.cnt   = 8'h00;
        end
        else
            filt_next.cnt = filt_reg.cnt + 8'h01;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            filt_reg <= '{meta: 1'b1, sync: 1'b1, level: 1'b1, cnt: 8'h00};
        else
            filt_reg <= filt_next;
    end

    assign levelOut = filt_reg.level;
endmodule : sst_pin_filter

// [hdl/sst_slave.sv]
// Two-wire slave front end with SCL-low timeout, address match and alert
// Contract
// [RULE_01] SCL low past timeout resets, frees SDA
// [RULE_02] Timeout counts only in frame, SCL low
// [RULE_03] Later revision: timeout covers both targets
// [RULE_04] Any SCL rate up to 400 kHz
// [RULE_05] Sample on SCL rise, change on fall
// [RULE_06] Suppress input spikes up to 100 ns
// [RULE_07] First valid reading within 100 ms
// [RULE_08] Open-drain alert on over/under limits
// [RULE_09] Address low bits from select pins
// [RULE_10] Host makes all SCL pulses
// [RULE_11] Preamble picks sensor or store, then R/W
// [RULE_12] Receiver acknowledges on ninth clock
// [RULE_13] No address ack during store write
// [RULE_14] START/STOP are SDA edges with SCL high
// [RULE_15] Timeout length is a parameter in window
`timescale 1ns/1ps
module sst_slave
    import sst_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter int unsigned POWERUP_CYCLES = POWERUP_CYC,
    parameter bit          LATE_REVISION  = 1'b1
)
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // Bus pins
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    input  wire logic [2:0] addrSelectPins,
    // Alert pin and its sources
    input  wire logic       alertEnable,
    input  wire logic       alertOverLimit,
    input  wire logic       alertUnderLimit,
    output logic            alertOut,
    output logic            alertOe,
    // Core side
    input  wire logic       storeWriteBusy,
    input  wire logic [7:0] txData,
    output logic [7:0]      rxData,
    output logic            rxValid,
    output logic            txTaken,
    output logic            targetStore,
    output logic            readMode,
    output logic            busActive,
    output logic            timeoutEvent,
    output logic            readingValid
);
    typedef struct packed
    {
        sst_state_e  state;
        logic        sclPrev;
        logic        sdaPrev;
        logic        frame;
        logic [3:0]  bitCnt;
        logic [7:0]  shift;
        logic        sdaLow;
        logic        store;
        logic        rd;
        logic [31:0] toCnt;
        logic [31:0] puCnt;
        logic        puDone;
        logic [7:0]  rxData;
        logic        rxValid;
        logic        txTaken;
        logic        timeout;
        logic [2:0]  pinMeta;
        logic [2:0]  pinSync;
    } sst_slave_s;

    sst_slave_s s_reg;
    sst_slave_s s_next;
    logic       scl;
    logic       sda;
    logic       sclRise;
    logic       sclFall;
    logic       startCond;
    logic       stopCond;

    // Filtered inputs: spikes never become edges or bus conditions
    sst_pin_filter u_sclFilt (.clock(clock), .resetn(resetn), // RULE_06
        .pinIn(sclIn), .levelOut(scl));
    sst_pin_filter u_sdaFilt (.clock(clock), .resetn(resetn), // RULE_06
        .pinIn(sdaIn), .levelOut(sda));

    // Edges come only from the host's clock; SCL is never driven here
    assign sclRise   = scl && !s_reg.sclPrev; // RULE_10
    assign sclFall   = !scl && s_reg.sclPrev;
    assign startCond = scl && s_reg.sclPrev && s_reg.sdaPrev && !sda; // RULE_14
    assign stopCond  = scl && s_reg.sclPrev && !s_reg.sdaPrev && sda; // RULE_14

    function automatic logic addrHit(input logic [7:0] a,
                                     input logic [2:0] pins);
        addrHit = (a[7:4] == PREAMBLE_SENSOR || a[7:4] == PREAMBLE_STORE)
                  && a[3:1] == pins; // RULE_09 RULE_11
    endfunction : addrHit

    always_comb
    begin
        s_next         = s_reg;
        s_next.sclPrev = scl;
        s_next.sdaPrev = sda;
        s_next.rxValid = 1'b0;
        s_next.txTaken = 1'b0;
        s_next.timeout = 1'b0;
        // Select pins are board levels from outside the clock domain
        s_next.pinMeta = addrSelectPins;
        s_next.pinSync = s_reg.pinMeta;
        if (s_reg.puCnt >= 32'(POWERUP_CYCLES - 1))
            s_next.puDone = 1'b1; // RULE_07
        else
            s_next.puCnt = s_reg.puCnt + 32'h1;
        // Counter is cleared whenever SCL is seen high
        if (!s_reg.frame || scl)
            s_next.toCnt = 32'h0; // RULE_02
        else
            s_next.toCnt = s_reg.toCnt + 32'h1; // RULE_02
        if (startCond)
        begin
            s_next.frame  = 1'b1;
            s_next.state  = SST_ADDR;
            s_next.bitCnt = 4'h0;
            s_next.sdaLow = 1'b0;
        end
        else if (stopCond)
        begin
            s_next.frame  = 1'b0;
            s_next.state  = SST_IDLE;
            s_next.sdaLow = 1'b0;
        end
        else if (sclRise)
        begin
            // Data sampled on the rising edge at SCL rates up to 400 kHz
            case (s_reg.state) // RULE_04
                SST_ADDR, SST_WDATA:
                begin
                    s_next.shift  = {s_reg.shift[6:0], sda}; // RULE_05
                    s_next.bitCnt = s_reg.bitCnt + 4'h1;
                end
                SST_RDATA:
                    s_next.bitCnt = s_reg.bitCnt + 4'h1;
                SST_MACK:
                    if (sda)
                        s_next.state = SST_IDLE; // Master NoACK ends read
                default:
                    ;
            endcase
        end
        else if (sclFall)
        begin
            // Data and ack changes of SDA happen on the falling edge; START, STOP and timeout only release it
            s_next.sdaLow = 1'b0; // RULE_05
            case (s_reg.state)
                SST_ADDR:
                    if (s_reg.bitCnt == ACK_BIT)
                    begin
                        // Busy store stays silent so host can poll
                        if (addrHit(s_reg.shift, s_reg.pinSync)
                            && !(s_reg.shift[7:4] == PREAMBLE_STORE
                                 && storeWriteBusy)) // RULE_13
                        begin
                            s_next.state  = SST_AACK;
                            s_next.sdaLow = 1'b1; // RULE_12
                            s_next.store  = s_reg.shift[7:4] == PREAMBLE_STORE;
                            s_next.rd     = s_reg.shift[0];
                        end
                        else
                            s_next.state = SST_IDLE;
                    end
                SST_AACK, SST_DACK:
                begin
                    s_next.bitCnt = 4'h0;
                    if (s_reg.rd)
                    begin
                        s_next.state   = SST_RDATA;
                        s_next.shift   = txData;
                        s_next.txTaken = 1'b1;
                        s_next.sdaLow  = !txData[7]; // RULE_05
                    end
                    else
                        s_next.state = SST_WDATA;
                end
                SST_WDATA:
                    if (s_reg.bitCnt == ACK_BIT)
                    begin
                        s_next.state   = SST_DACK;
                        s_next.sdaLow  = 1'b1; // RULE_12
                        s_next.rxData  = s_reg.shift;
                        s_next.rxValid = 1'b1;
                    end
                SST_RDATA:
                    if (s_reg.bitCnt == ACK_BIT)
                        s_next.state = SST_MACK;
                    else
                    begin
                        s_next.shift  = {s_reg.shift[6:0], 1'b1};
                        s_next.sdaLow = !s_reg.shift[6]; // RULE_05
                    end
                SST_MACK:
                    s_next.state = SST_DACK;
                default:
                    ;
            endcase
        end
        // Timeout resets the interface; the early part spares the store
        if (s_reg.toCnt >= 32'(TIMEOUT_CYCLES - 1)
            && (LATE_REVISION || !s_reg.store)) // RULE_03 RULE_15
        begin
            s_next.state   = SST_IDLE; // RULE_01
            s_next.frame   = 1'b0;
            s_next.sdaLow  = 1'b0; // RULE_01
            s_next.toCnt   = 32'h0;
            s_next.timeout = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            s_reg <= '{state: SST_IDLE, sclPrev: 1'b1, sdaPrev: 1'b1,
                       default: '0};
        else
            s_reg <= s_next;
    end

    assign sdaOut       = 1'b0;
    assign sdaOe        = !s_reg.sdaLow;
    assign alertOut     = 1'b0;
    // Open-drain alert: pulled low only while enabled and out of limits
    assign alertOe      = !(alertEnable && s_reg.puDone
                            && (alertOverLimit || alertUnderLimit)); // RULE_08
    assign rxData       = s_reg.rxData;
    assign rxValid      = s_reg.rxValid;
    assign txTaken      = s_reg.txTaken;
    assign targetStore  = s_reg.store;
    assign readMode     = s_reg.rd;
    assign busActive    = s_reg.frame;
    assign timeoutEvent = s_reg.timeout;
    assign readingValid = s_reg.puDone;

    AST_TIMEOUT_RELEASE: assert property (@(posedge clock) disable iff (!resetn)
        s_reg.timeout |-> sdaOe && !s_reg.frame) // RULE_01
        else $error("timeout did not free SDA");
    AST_TIMEOUT_CLEAR: assert property (@(posedge clock) disable iff (!resetn)
        $past(scl) |-> s_reg.toCnt == 32'h0) // RULE_02
        else $error("timeout count not cleared by SCL high");
    AST_NO_SDA_CHANGE_HIGH: assert property (@(posedge clock)
        disable iff (!resetn)
        $changed(s_reg.sdaLow) |-> !$past(sclRise)) // RULE_05
        else $error("SDA changed on rising SCL");
    sequence ADDR_NINTH;
        s_reg.state == SST_ADDR && s_reg.bitCnt == ACK_BIT && sclFall;
    endsequence
    AST_ADDR_ACK: assert property (@(posedge clock) disable iff (!resetn)
        ADDR_NINTH ##1 (s_reg.state == SST_AACK) |-> s_reg.sdaLow) // RULE_12
        else $error("address ack missing");
    AST_BUSY_NACK: assert property (@(posedge clock) disable iff (!resetn)
        ADDR_NINTH and (storeWriteBusy && s_reg.shift[7:4] == PREAMBLE_STORE)
        |=> !s_reg.sdaLow) // RULE_13
        else $error("acked store while busy");
    AST_MATCH_PINS: assert property (@(posedge clock) disable iff (!resetn)
        $rose(s_reg.state == SST_AACK) |-> $past(s_reg.shift[3:1])
        == $past(s_reg.pinSync)) // RULE_09
        else $error("ack without pin match");
    AST_STOP_IDLE: assert property (@(posedge clock) disable iff (!resetn)
        stopCond |=> s_reg.state == SST_IDLE && !s_reg.frame) // RULE_14
        else $error("stop not honoured");
    AST_POWERUP: assert property (@(posedge clock) disable iff (!resetn)
        s_reg.puCnt >= 32'(POWERUP_CYCLES - 1) |=> readingValid) // RULE_07
        else $error("reading not valid in time");
    AST_ALERT: assert property (@(posedge clock) disable iff (!resetn)
        (alertEnable && readingValid && alertOverLimit) |-> !alertOe) // RULE_08
        else $error("alert not driven");
endmodule : sst_slave

// [bench/sst_host_model.sv]
// Host bus master model: makes every clock pulse, drives data open-drain
`timescale 1ns/1ps
module sst_host_model
(
    // Clock and slave data enable
    input  wire logic clock,
    input  wire logic sdaOe,
    // Bus levels
    output logic      scl,
    output logic      sda
);
    logic hostPull;

    // Pull-up on the wire: a released line reads high, never stale
    assign sda = (hostPull || sdaOe === 1'b0) ? 1'b0 : 1'b1;

    initial
    begin
        scl      = 1'b1;
        hostPull = 1'b0;
    end

    // One 800 ns clock with a long low phase: the slave's reply lands
    // about 450 ns after the fall and must settle before SCL rises,
    // or its filtered edge would look like a START or STOP
    task automatic bitx(input logic b, output logic r);
        repeat (2) @(negedge clock);
        hostPull = !b;
        repeat (4) @(negedge clock);
        scl = 1'b1;
        repeat (2) @(negedge clock);
        r   = sda;
        scl = 1'b0;
    endtask : bitx

    task automatic startCond();
        repeat (2) @(negedge clock);
        hostPull = 1'b0;
        repeat (2) @(negedge clock);
        scl = 1'b1;
        repeat (4) @(negedge clock);
        hostPull = 1'b1;
        repeat (4) @(negedge clock);
        scl = 1'b0;
    endtask : startCond

    task automatic stopCond();
        repeat (2) @(negedge clock);
        hostPull = 1'b1;
        repeat (2) @(negedge clock);
        scl = 1'b1;
        repeat (4) @(negedge clock);
        hostPull = 1'b0;
        repeat (8) @(negedge clock);
    endtask : stopCond

    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(d[i], r);
        bitx(1'b1, r);
        ack = (r === 1'b0);
    endtask : sendByte

    task automatic recvByte(input logic ackIt, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(!ackIt, r);
    endtask : recvByte

    // Exactly 100 ns low on data: must not look like a bus condition
    task automatic spike();
        hostPull = 1'b1;
        @(negedge clock);
        hostPull = 1'b0;
    endtask : spike
endmodule : sst_host_model

// [bench/testbench.sv]
// Self-checking bench for the two-wire slave front end
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin nTests++; if ((got) !== (ex)) begin \
    errTotal++; \
    $display("wrong value %s exp %h got %h", nm, ex, got); end end
module testbench;
    logic       clock = 1'b0;
    logic       resetn = 1'b0;
    logic [2:0] addrSelectPins = 3'h5;
    logic       alertEnable = 1'b0;
    logic       alertOverLimit = 1'b0;
    logic       alertUnderLimit = 1'b0;
    logic       storeWriteBusy = 1'b0;
    logic [7:0] txData = 8'h00;
    logic       scl, sda, sdaOut, sdaOe, alertOut, alertOe;
    logic       rxValid, txTaken, targetStore, readMode, busActive;
    logic       timeoutEvent, readingValid, toSeen, rxSeen, ack, txSeen;
    logic [7:0] rxData, d;
    int         errTotal = 0;
    int         nTests = 0;

    always #50 clock = ~clock;

    // Pulses are latched so that a scenario can judge them later
    always @(posedge clock)
    begin
        if (timeoutEvent === 1'b1) toSeen <= 1'b1;
        if (rxValid === 1'b1) rxSeen <= 1'b1;
        if (txTaken === 1'b1) txSeen <= 1'b1;
    end

    sst_host_model host (.clock(clock), .sdaOe(sdaOe), .scl(scl),
        .sda(sda));

    // Short counts keep the run brief
    sst_slave #(.TIMEOUT_CYCLES(200), .POWERUP_CYCLES(50)) u_sst_slave (
        .clock(clock), .resetn(resetn), .sclIn(scl), .sdaIn(sda),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelectPins(addrSelectPins),
        .alertEnable(alertEnable), .alertOverLimit(alertOverLimit),
        .alertUnderLimit(alertUnderLimit), .alertOut(alertOut),
        .alertOe(alertOe), .storeWriteBusy(storeWriteBusy),
        .txData(txData), .rxData(rxData), .rxValid(rxValid),
        .txTaken(txTaken), .targetStore(targetStore),
        .readMode(readMode), .busActive(busActive),
        .timeoutEvent(timeoutEvent), .readingValid(readingValid));

    task automatic scnPowerUp();
        repeat (40) @(negedge clock);
        `CHK("readingValid", 1'b0, readingValid)
        repeat (20) @(negedge clock);
        `CHK("readingValid", 1'b1, readingValid)
    endtask : scnPowerUp

    task automatic scnAlert();
        // Enable, over, under, expected enable level
        logic [3:0] t [4] = '{4'b1100, 4'b1010, 4'b0111, 4'b1001};
        foreach (t[i])
        begin
            {alertEnable, alertOverLimit, alertUnderLimit} = t[i][3:1];
            repeat (3) @(negedge clock);
            `CHK("alertOe", t[i][0], alertOe)
        end
    endtask : scnAlert

    task automatic scnGlitch();
        repeat (8) @(negedge clock);
        host.spike();
        repeat (10) @(negedge clock);
        `CHK("busActive", 1'b0, busActive)
    endtask : scnGlitch

    task automatic scnWrite();
        rxSeen = 1'b0;
        host.startCond();
        host.sendByte(8'h3a, ack);
        `CHK("addrAck", 1'b1, ack)
        `CHK("targetStore", 1'b0, targetStore)
        `CHK("busActive", 1'b1, busActive)
        host.sendByte(8'ha5, ack);
        `CHK("dataAck", 1'b1, ack)
        `CHK("rxData", 8'ha5, rxData)
        `CHK("rxValid", 1'b1, rxSeen)
        host.stopCond();
        `CHK("busActive", 1'b0, busActive)
    endtask : scnWrite

    task automatic scnRead();
        txData = 8'h3c;
        txSeen = 1'b0;
        host.startCond();
        host.sendByte(8'hab, ack);
        `CHK("addrAck", 1'b1, ack)
        `CHK("readMode", 1'b1, readMode)
        host.recvByte(1'b0, d);
        `CHK("readByte", 8'h3c, d)
        `CHK("txTaken", 1'b1, txSeen)
        host.stopCond();
        `CHK("sdaOe", 1'b1, sdaOe)
    endtask : scnRead

    task automatic scnRefuse();
        logic [7:0] a [3] = '{8'h38, 8'h5a, 8'haa};
        storeWriteBusy = 1'b1;
        foreach (a[i])
        begin
            host.startCond();
            host.sendByte(a[i], ack);
            `CHK("noAck", 1'b0, ack)
            host.stopCond();
        end
        storeWriteBusy = 1'b0;
        host.startCond();
        host.sendByte(8'haa, ack);
        `CHK("addrAck", 1'b1, ack)
        `CHK("targetStore", 1'b1, targetStore)
        host.stopCond();
        // Moving the select pins moves the address that is answered
        addrSelectPins = 3'h4;
        host.startCond();
        host.sendByte(8'h38, ack);
        `CHK("pinAck", 1'b1, ack)
        host.stopCond();
        addrSelectPins = 3'h5;
    endtask : scnRefuse

    // Store target: the later revision must time out there as well
    task automatic scnTimeout();
        toSeen = 1'b0;
        host.startCond();
        host.sendByte(8'haa, ack);
        repeat (150) @(negedge clock);
        host.bitx(1'b1, ack);
        repeat (150) @(negedge clock);
        `CHK("timeoutEvent", 1'b0, toSeen)
        `CHK("busActive", 1'b1, busActive)
        repeat (100) @(negedge clock);
        `CHK("timeoutEvent", 1'b1, toSeen)
        `CHK("busActive", 1'b0, busActive)
        `CHK("sdaOe", 1'b1, sdaOe)
        host.stopCond();
    endtask : scnTimeout

    task automatic report_and_stop();
        $display("checks %0d errors %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (12) @(negedge clock);
        `CHK("sdaOe", 1'b1, sdaOe)
        `CHK("alertOe", 1'b1, alertOe)
        `CHK("sdaOut", 1'b0, sdaOut)
        `CHK("alertOut", 1'b0, alertOut)
        resetn = 1'b1;
        scnPowerUp();
        scnAlert();
        scnGlitch();
        scnWrite();
        scnRead();
        scnRefuse();
        scnTimeout();
        report_and_stop();
    end
endmodule : testbench
